/* rtl/keypad_led_scan_pkg.sv */
// Constants and types for the keypad and LED scan port
package keypad_led_scan_pkg;
  localparam int DIGIT_COUNT = 10;
  localparam int KEY_ROWS = 9;
  localparam int KEY_COLS = 5;
  localparam int SEG_COUNT = 8;

  // Register byte offsets
  localparam logic [11:0] PORT_OFS = 12'h400;
  localparam logic [11:0] STATUS_OFS = 12'h404;
  localparam logic [11:0] MASK_OFS = 12'h408;

  // Field positions within the port word
  localparam int COL_LSB = 1;
  localparam int MASK_LSB = 1;
  localparam int MASK_MSB = 15;
  localparam int DIGSEL_LSB = 16;
  localparam int SEG_LSB = 20;
  localparam int KEEPALIVE_BIT = 28;
  localparam int OUT_LSB = 16;

  // Status word fields
  localparam int STAT_BLANK_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;

  // Reset values
  localparam logic [31:0] PORT_RESET = 32'hffff0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;

  // Fail-safe timeout
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int FAILSAFE_TIME_MS = 10;
  localparam int FAILSAFE_CYCLES = FAILSAFE_TIME_MS * CLK_FREQ_KHZ;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic keepAlive;
    logic [SEG_COUNT-1:0] segment;
    logic [3:0] digitSelect;
  } scan_out_t;
endpackage : keypad_led_scan_pkg

/* rtl/keypad_led_scan_port.sv */
// AXI4-Lite scan port for a ten-digit LED display and 9x5 key matrix
`timescale 1ns/10ps
// Function
// - Drive ten used digits, numbered 1 to 10 from the left.
// - Segment sourced only when its line and display enable are both low.
// - Digit line low through one-of-ten decode; code zero selects digit 1.
// - Four-bit select decoded into ten mutually exclusive active-low lines.
// - Fail-safe timer blanks display unless keep-alive pulses keep coming.
// - Keyboard is 45 switches in 9 rows by 5 columns.
// - Digit lines 1 to 9 also drive keyboard rows.
// - Columns idle high; low means key closed to enabled row.
// - Masked input makes no interrupt yet stays readable.
// - Port occupies the address range starting at 400 hex, 32 bits.
module keypad_led_scan_port
  import keypad_led_scan_pkg::*;
#(
  parameter int FailsafeCycles = FAILSAFE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [KEY_COLS-1:0] key_column_n,
  output logic [DIGIT_COUNT-1:0] digit_n,
  output logic [KEY_ROWS-1:0] key_row_n,
  output logic [SEG_COUNT-1:0] segment_n,
  output logic display_enable_n,
  output logic irq_request_n
);
  // Elaboration checks: 24-bit timer, carrier matches the port output field
  if (FailsafeCycles < 1 || FailsafeCycles > 32'h00ffffff) begin : g_failsafe_range
    $error("FailsafeCycles out of range");
  end
  if ($bits(scan_out_t) != KEEPALIVE_BIT - OUT_LSB + 1) begin : g_carrier_width
    $error("scan_out_t does not match the port output field");
  end
  if (KEY_ROWS > DIGIT_COUNT) begin : g_row_count
    $error("more key rows than digit lines");
  end

  localparam logic [23:0] RELOAD = FailsafeCycles[23:0];

  // Word address: the two low address bits are ignored
  function automatic logic [11:0] wordAddr(input logic [11:0] addr);
    return {addr[11:2], 2'b00};
  endfunction : wordAddr

  // Strobed byte lanes take the new data
  function automatic logic [31:0] mergeLanes(
    input logic [31:0] oldWord,
    input logic [31:0] newWord,
    input logic [3:0] strb
  );
    logic [31:0] merged;
    merged = oldWord;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merged[b*8 +: 8] = newWord[b*8 +: 8];
      end
    end
    return merged;
  endfunction : mergeLanes

  // One-of-ten decode; codes 10 to 15 leave every line high
  function automatic logic [DIGIT_COUNT-1:0] decodeDigit(input logic [3:0] sel);
    logic [DIGIT_COUNT-1:0] lines;
    lines = '1;
    for (int i = 0; i < DIGIT_COUNT; i++) begin
      if (sel == i[3:0]) begin
        lines[i] = 1'b0;
      end
    end
    return lines;
  endfunction : decodeDigit

  logic [31:0] portQ, portD;
  logic [15:0] maskQ, maskD;
  logic [23:0] timerQ, timerD;
  // Write and read channel state
  logic awHeldQ, awHeldD;
  logic wHeldQ, wHeldD;
  logic [11:0] awAddrQ, awAddrD;
  logic [31:0] wDataQ, wDataD;
  logic [3:0] wStrbQ, wStrbD;
  logic awReadyQ, awReadyD;
  logic wReadyQ, wReadyD;
  logic bValidQ, bValidD;
  logic arReadyQ, arReadyD;
  logic rValidQ, rValidD;
  logic [1:0] bRespQ, bRespD;
  logic [1:0] rRespQ, rRespD;
  logic [31:0] rDataQ, rDataD;
  // Display outputs and interrupt
  logic [DIGIT_COUNT-1:0] digitQ, digitD;
  logic [KEY_ROWS-1:0] rowQ, rowD;
  logic [SEG_COUNT-1:0] segQ, segD;
  logic blankQ, blankD;
  logic irqNQ, irqND;
  scan_out_t scanNext;
  logic [31:0] portRead;
  logic [15:0] pendingNext;

  // Column pins read in place of the stored bits; other inputs idle high
  always_comb begin
    portRead = portQ;
    portRead[MASK_MSB:MASK_LSB] = '1;
    portRead[COL_LSB +: KEY_COLS] = key_column_n;
  end

  // Write channel with port and mask registers
  always_comb begin
    portD = portQ;
    maskD = maskQ;
    awHeldD = awHeldQ;
    wHeldD = wHeldQ;
    awAddrD = awAddrQ;
    wDataD = wDataQ;
    wStrbD = wStrbQ;
    bValidD = bValidQ;
    bRespD = bRespQ;
    if (s_axi_awvalid && awReadyQ) begin
      awHeldD = 1'b1;
      awAddrD = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReadyQ) begin
      wHeldD = 1'b1;
      wDataD = s_axi_wdata;
      wStrbD = s_axi_wstrb;
    end
    if (awHeldQ && wHeldQ && !bValidQ) begin
      awHeldD = 1'b0;
      wHeldD = 1'b0;
      bValidD = 1'b1;
      bRespD = RESP_OKAY;
      unique case (wordAddr(awAddrQ))
        PORT_OFS: portD = mergeLanes(portQ, wDataQ, wStrbQ);
        MASK_OFS: begin
          for (int b = 0; b < 2; b++) begin
            if (wStrbQ[b]) begin
              maskD[b*8 +: 8] = wDataQ[b*8 +: 8];
            end
          end
          maskD[0] = 1'b0;
        end
        STATUS_OFS: bRespD = RESP_OKAY;
        default: bRespD = RESP_SLVERR;
      endcase
    end
    if (bValidQ && s_axi_bready) begin
      bValidD = 1'b0;
    end
    // No new write until the response is taken
    awReadyD = !awHeldD && !bValidD;
    wReadyD = !wHeldD && !bValidD;
  end

  // Read channel; one read under way at a time
  always_comb begin
    rValidD = rValidQ;
    rRespD = rRespQ;
    rDataD = rDataQ;
    if (rValidQ && s_axi_rready) begin
      rValidD = 1'b0;
    end
    if (s_axi_arvalid && arReadyQ) begin
      rValidD = 1'b1;
      rRespD = RESP_OKAY;
      unique case (wordAddr(s_axi_araddr))
        PORT_OFS: rDataD = portRead;
        MASK_OFS: rDataD = {16'h0000, maskQ};
        STATUS_OFS: begin
          rDataD = 32'h00000000;
          rDataD[STAT_BLANK_BIT] = blankQ;
          rDataD[STAT_IRQ_BIT] = !irqNQ;
        end
        default: begin
          rDataD = 32'h00000000;
          rRespD = RESP_SLVERR;
        end
      endcase
    end
    // Next read accepted once the data is taken
    arReadyD = !rValidD;
  end

  // Display drive, fail-safe timer, key rows and interrupt request
  always_comb begin
    scanNext = portD[KEEPALIVE_BIT:OUT_LSB];
    timerD = timerQ;
    // Falling edge of the keep-alive line restarts the timer
    if (portQ[KEEPALIVE_BIT] && !scanNext.keepAlive) begin
      timerD = RELOAD;
    end else if (timerQ != 24'h000000) begin
      timerD = timerQ - 24'h000001;
    end
    blankD = (timerD == 24'h000000);
    digitD = decodeDigit(scanNext.digitSelect);
    rowD = digitD[KEY_ROWS-1:0];
    segD = scanNext.segment | {SEG_COUNT{blankD}};
    pendingNext = 16'h0000;
    pendingNext[COL_LSB +: KEY_COLS] = ~key_column_n;
    irqND = !(|(pendingNext & maskD));
  end

  // Write channel, port and mask registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      portQ <= PORT_RESET;
      maskQ <= MASK_RESET;
      awHeldQ <= 1'b0;
      wHeldQ <= 1'b0;
      awAddrQ <= 12'h000;
      wDataQ <= 32'h00000000;
      wStrbQ <= 4'h0;
      awReadyQ <= 1'b0;
      wReadyQ <= 1'b0;
      bValidQ <= 1'b0;
      bRespQ <= RESP_OKAY;
    end else if (ce) begin
      portQ <= portD;
      maskQ <= maskD;
      awHeldQ <= awHeldD;
      wHeldQ <= wHeldD;
      awAddrQ <= awAddrD;
      wDataQ <= wDataD;
      wStrbQ <= wStrbD;
      awReadyQ <= awReadyD;
      wReadyQ <= wReadyD;
      bValidQ <= bValidD;
      bRespQ <= bRespD;
    end
  end

  // Read channel registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arReadyQ <= 1'b0;
      rValidQ <= 1'b0;
      rRespQ <= RESP_OKAY;
      rDataQ <= 32'h00000000;
    end else if (ce) begin
      arReadyQ <= arReadyD;
      rValidQ <= rValidD;
      rRespQ <= rRespD;
      rDataQ <= rDataD;
    end
  end

  // Display, fail-safe timer and interrupt registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerQ <= 24'h000000;
      digitQ <= '1;
      rowQ <= '1;
      segQ <= '1;
      blankQ <= 1'b1;
      irqNQ <= 1'b1;
    end else if (ce) begin
      timerQ <= timerD;
      digitQ <= digitD;
      rowQ <= rowD;
      segQ <= segD;
      blankQ <= blankD;
      irqNQ <= irqND;
    end
  end

  // Outputs straight from registers
  assign s_axi_awready = awReadyQ;
  assign s_axi_wready = wReadyQ;
  assign s_axi_bvalid = bValidQ;
  assign s_axi_bresp = bRespQ;
  assign s_axi_arready = arReadyQ;
  assign s_axi_rvalid = rValidQ;
  assign s_axi_rresp = rRespQ;
  assign s_axi_rdata = rDataQ;
  assign digit_n = digitQ;
  assign key_row_n = rowQ;
  assign segment_n = segQ;
  assign display_enable_n = blankQ;
  assign irq_request_n = irqNQ;
endmodule : keypad_led_scan_port

/* verif/keypad_led_scan_assertions.sv */
// Concurrent checks on the scan port pins
`timescale 1ns/10ps
module keypad_led_scan_assertions
  import keypad_led_scan_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic [KEY_COLS-1:0] key_column_n,
  input wire logic [DIGIT_COUNT-1:0] digit_n,
  input wire logic [KEY_ROWS-1:0] key_row_n,
  input wire logic [SEG_COUNT-1:0] segment_n,
  input wire logic display_enable_n,
  input wire logic irq_request_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_digit_onehot; $onehot0(~digit_n); endproperty
  a_digit_onehot: assert property (p_digit_onehot) else $error("two digits low");
  property p_row_follows; key_row_n == digit_n[KEY_ROWS-1:0]; endproperty
  a_row_follows: assert property (p_row_follows) else $error("row not digit");
  property p_blank_dark; display_enable_n |-> &segment_n; endproperty
  a_blank_dark: assert property (p_blank_dark) else $error("segment lit while blank");
  property p_enable_hold; $fell(display_enable_n) |=> !display_enable_n [*8]; endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("blank too soon");
  property p_digit_on_write; $changed(digit_n) |-> $rose(s_axi_bvalid); endproperty
  a_digit_on_write: assert property (p_digit_on_write) else $error("digit moved alone");
  property p_irq_idle; ce && (&key_column_n) |=> irq_request_n; endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq without key");
  property p_irq_cause; $fell(irq_request_n) |-> !$past(&key_column_n); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  property p_bus_refuse; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_bus_refuse: assert property (p_bus_refuse) else $error("address taken early");
endmodule : keypad_led_scan_assertions

/* verif/key_matrix_model.sv */
// Key matrix with pulled-up column lines
`timescale 1ns/10ps
module key_matrix_model
  import keypad_led_scan_pkg::*;
(
  input wire logic [KEY_ROWS-1:0] key_row_n,
  input wire logic [KEY_ROWS*KEY_COLS-1:0] keyDown,
  output logic [KEY_COLS-1:0] key_column_n
);
  always_comb begin
    key_column_n = 5'h1f;
    for (int r = 0; r < KEY_ROWS; r++) begin
      for (int c = 0; c < KEY_COLS; c++) begin
        if (!key_row_n[r] && keyDown[r*KEY_COLS+c]) key_column_n[c] = 1'b0;
      end
    end
  end
endmodule : key_matrix_model

/* verif/keypad_led_scan_port_tb.sv */
// Bench for the keypad and LED scan port
`timescale 1ns/10ps
module keypad_led_scan_port_tb;
  import keypad_led_scan_pkg::*;
  localparam int FS = 20;
  logic ref_clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, displayEnableN, irqRequestN;
  logic [1:0] bresp, rresp, rs;
  logic [KEY_COLS-1:0] keyColumnN;
  logic [DIGIT_COUNT-1:0] digitN, ex;
  logic [KEY_ROWS-1:0] keyRowN;
  logic [SEG_COUNT-1:0] segmentN;
  logic [44:0] keyDown = 45'h0;
  int miscompares = 0, nTests = 0;
  keypad_led_scan_port #(.FailsafeCycles(FS)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .key_column_n(keyColumnN), .digit_n(digitN), .key_row_n(keyRowN), .segment_n(segmentN),
    .display_enable_n(displayEnableN), .irq_request_n(irqRequestN));
  key_matrix_model keys (.key_row_n(keyRowN), .keyDown(keyDown), .key_column_n(keyColumnN));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : axw
  task automatic axr(input logic [11:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask : axr
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk("digit", 32'h3ff, {22'h0, digitN});
    chk("blank", 32'h1, {31'h0, displayEnableN});
    axr(PORT_OFS);
    chk("port", 32'hfffffffe, rd);
    for (int c = 0; c < 16; c++) begin
      keyDown <= (c < 9) ? (45'h1 << (c * 5 + c % 5)) : 45'h0;
      axw(PORT_OFS, {3'h7, c[0], 8'h5a ^ c[7:0], c[3:0], 16'h0}, RESP_OKAY);
      ex = (c < 10) ? ~(10'h1 << c) : 10'h3ff;
      chk("digit", {22'h0, ex}, {22'h0, digitN});
      chk("row", {23'h0, ex[8:0]}, {23'h0, keyRowN});
      chk("segment", {24'h0, 8'h5a ^ c[7:0]}, {24'h0, segmentN});
      chk("enable", 32'h0, {31'h0, displayEnableN});
      axr(PORT_OFS);
      chk("column", (c < 9) ? ~(32'h1 << (c % 5)) & 32'h1f : 32'h1f, {27'h0, rd[5:1]});
      chk("masked", 32'h1, {31'h0, irqRequestN});
    end
    keyDown <= 45'h1 << 11;
    axw(PORT_OFS, 32'he0020000, RESP_OKAY);
    axw(MASK_OFS, 32'h3e, RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h0, {31'h0, irqRequestN});
    axr(STATUS_OFS);
    chk("status", 32'h2, rd);
    axw(MASK_OFS, 32'h0, RESP_OKAY);
    repeat (3) @(posedge ref_clk);
    chk("irq", 32'h1, {31'h0, irqRequestN});
    axw(12'h40c, 32'h0, RESP_SLVERR);
    axr(12'h40c);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    chk("rdata", 32'h0, rd);
    axw(PORT_OFS, 32'hf0020000, RESP_OKAY);
    axw(PORT_OFS, 32'he0020000, RESP_OKAY);
    ce <= 1'b0;
    repeat (FS + 5) @(posedge ref_clk);
    chk("frozen", 32'h0, {31'h0, displayEnableN});
    ce <= 1'b1;
    repeat (FS / 2) @(posedge ref_clk);
    chk("enable", 32'h0, {31'h0, displayEnableN});
    repeat (FS + 5) @(posedge ref_clk);
    chk("blank", 32'h1, {31'h0, displayEnableN});
    chk("dark", 32'hff, {24'h0, segmentN});
    report_and_stop();
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end
endmodule : keypad_led_scan_port_tb
bind keypad_led_scan_port keypad_led_scan_assertions assertChk (.ref_clk(ref_clk),
  .rst_n(rst_n), .ce(ce), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .key_column_n(key_column_n), .digit_n(digit_n), .key_row_n(key_row_n),
  .segment_n(segment_n), .display_enable_n(display_enable_n), .irq_request_n(irq_request_n));
